// File: rtl/fpx_params.svh
// Purpose: Constants of the floating point exception logic
// Assumes: Single clock, synchronous active-high reset
// Notes:   Field positions follow the exceptions field layout
//
// Behaviour
// - Overflow untrapped: nearest gives signed infinity, toward zero gives signed max finite
// - Overflow untrapped: up/down rounding give max finite or infinity by sign
// - Underflow is never flagged; possible underflow raises unimplemented instead
// - Inexact is flagged when the rounded result differs or overflows
// - Operand exponents near limits force stall mode, one risky op at a time
// - Inexact traps enabled force stall mode for every multi-cycle operation
// - A taken trap leaves destination unchanged and sources untouched
// - Inexact untrapped writes the rounded or overflowed value unless another trap
// - Listed invalid cases and signaling NaN arithmetic flag invalid operation
// - Move is not arithmetic; abs and negate are, for signaling NaN
// - Invalid untrapped cases raise unimplemented instead of a NaN
// - Divide by zero only for zero divisor and finite non-zero dividend
// - Divide by zero untrapped writes a correctly signed infinity
// - Overflow when rounded magnitude exceeds max finite; also sets inexact
// - Reserved opcode or format field raises unimplemented
// - Unimplemented cannot be masked and always interrupts the core
// - Denormal operands, quiet NaN operands except in compares, denormal results, underflow raise unimplemented; move is exempt
// - Status read waits for in-flight ops and shows their exceptions
// - Exceptions field holds the outcome of the latest instruction that raised an exception
// - Writing zero to the exceptions field clears all its bits
// - IEEE exception sets its exception and sticky bits; trap only if enabled
`ifndef FPX_PARAMS_SVH
`define FPX_PARAMS_SVH
`define FPX_EXC_I      0
`define FPX_EXC_U      1
`define FPX_EXC_O      2
`define FPX_EXC_Z      3
`define FPX_EXC_V      4
`define FPX_EXC_E      5
`define FPX_EXC_RST    6'h00
`define FPX_STICKY_RST 5'h00
`define FPX_OPC_MSB    31
`define FPX_OPC_LSB    26
`define FPX_FMT_MSB    24
`define FPX_FMT_LSB    21
`define FPX_OPC_LEGAL  6'h11
`define FPX_FMT_S      4'h0
`define FPX_FMT_D      4'h1
`define FPX_EXP_ONES_S 11'h0FF
`define FPX_EXP_ONES_D 11'h7FF
`define FPX_EXP_MARGIN 11'h002
`define FPX_INF_S      32'h7F800000
`define FPX_MAX_S      32'h7F7FFFFF
`define FPX_INF_D      64'h7FF0000000000000
`define FPX_MAX_D      64'h7FEFFFFFFFFFFFFF
`define FPX_INFL_W     4
`endif

// File: rtl/fpx_pkg.sv
// Purpose: Types of the floating point exception logic
// Assumes: Rounding mode port encodes modes in enum order
// Notes:   No constants here; see fpx_params.svh
package fpx_pkg;
  typedef enum logic [1:0] {
    round_to_nearest,
    round_toward_zero,
    round_up_positive,
    round_down_negative
  } fpx_rmode_t;
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_ABS, OP_NEG, OP_MOV,
    OP_CVT_FIX, OP_CVT_FLT, OP_CMP_ORD, OP_CMP_UNORD, OP_OTHER
  } fpx_op_t;
  typedef enum logic {
    ST_IDLE,
    ST_STALL
  } fpx_state_t;
endpackage : fpx_pkg

// File: rtl/fpx_classify.sv
// Purpose: Classify one operand of either format
// Assumes: Single operands sit in the low 32 bits
// Notes:   Pure combinational
`timescale 1ns/1ps
`include "fpx_params.svh"
module fpx_classify (
  input  wire logic        dbl,
  input  wire logic [63:0] opnd,
  output logic             is_zero,
  output logic             is_inf,
  output logic             is_nan,
  output logic             is_snan,
  output logic             is_den,
  output logic             risky,
  output logic             sign
);
  logic [10:0] expo;
  logic [10:0] ones;
  logic        man_nz;
  logic        quiet;
  assign expo   = dbl ? opnd[62:52] : {3'h0, opnd[30:23]};
  assign ones   = dbl ? `FPX_EXP_ONES_D : `FPX_EXP_ONES_S;
  assign man_nz = dbl ? |opnd[51:0] : |opnd[22:0];
  assign quiet  = dbl ? opnd[51] : opnd[22];
  assign sign   = dbl ? opnd[63] : opnd[31];
  assign is_zero = (expo == 11'h000) && !man_nz;
  assign is_den  = (expo == 11'h000) && man_nz;
  assign is_inf  = (expo == ones) && !man_nz;
  assign is_nan  = (expo == ones) && man_nz;
  assign is_snan = is_nan && !quiet;
  // Exponents near either end may overflow or underflow
  assign risky = (expo >= ones - `FPX_EXP_MARGIN) ||
                 ((expo != 11'h000) && (expo <= `FPX_EXP_MARGIN));
endmodule : fpx_classify

// File: rtl/fpx_default.sv
// Purpose: Default result for untrapped overflow and divide by zero
// Assumes: Single results sit in the low 32 bits
// Notes:   Pure combinational
`timescale 1ns/1ps
`include "fpx_params.svh"
module fpx_default (
  input  wire logic                 dbl,
  input  wire logic                 sign,
  input  wire logic                 div_zero,
  input  wire fpx_pkg::fpx_rmode_t  rmode,
  output logic [63:0]               value
);
  logic to_inf;
  always_comb begin
    case (rmode)
      fpx_pkg::round_to_nearest:    to_inf = 1'b1;
      fpx_pkg::round_toward_zero:   to_inf = 1'b0;
      fpx_pkg::round_up_positive:   to_inf = !sign;
      fpx_pkg::round_down_negative: to_inf = sign;
      default:                      to_inf = 1'b1;
    endcase
    if (div_zero) begin
      to_inf = 1'b1;
    end
    if (dbl) begin
      value = {sign, to_inf ? 63'(`FPX_INF_D) : 63'(`FPX_MAX_D)};
    end else begin
      value = {32'h0, sign, to_inf ? 31'(`FPX_INF_S) : 31'(`FPX_MAX_S)};
    end
  end
endmodule : fpx_default

// File: rtl/fpx_exception_logic.sv
// Purpose: Exception detection and response of the floating point unit
// Assumes: Datapath reports rounding flags with each result
// Notes:   Issue-time exceptions cancel the op; result-time ones gate the write
`timescale 1ns/1ps
`include "fpx_params.svh"
module fpx_exception_logic (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        issue_valid,
  input  wire logic [31:0] issue_instr,
  input  wire logic [3:0]  issue_op,
  input  wire logic        issue_multi,
  input  wire logic [63:0] op_a,
  input  wire logic [63:0] op_b,
  output logic             issue_ready,
  output logic             issue_dispatch,
  output logic             issue_stalled,
  input  wire logic        res_valid,
  input  wire logic        res_dbl,
  input  wire logic        res_sign,
  input  wire logic        res_inexact,
  input  wire logic        res_overflow,
  input  wire logic        res_underflow,
  input  wire logic        res_denorm,
  input  wire logic        res_cvt_ovf,
  input  wire logic [63:0] res_value,
  input  wire logic [1:0]  round_mode,
  input  wire logic [4:0]  trap_en,
  input  wire logic        csr_wr,
  input  wire logic [5:0]  csr_wr_exc,
  input  wire logic [4:0]  csr_wr_sticky,
  input  wire logic        csr_rd_req,
  output logic             csr_rd_ack,
  output logic [5:0]       csr_rd_exc,
  output logic [4:0]       csr_rd_sticky,
  output logic             wr_en,
  output logic [63:0]      wr_data,
  output logic [5:0]       exc_field,
  output logic [4:0]       sticky_field,
  output logic             trap_taken,
  output logic             fp_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  fpx_pkg::fpx_state_t state_ff;
  fpx_pkg::fpx_state_t nxt_state;
  fpx_pkg::fpx_op_t    op;
  logic [`FPX_INFL_W-1:0] infl_ff;
  logic [5:0]  exc_ff;
  logic [4:0]  sticky_ff;
  logic        rd_ack_ff;
  logic [5:0]  rd_exc_ff;
  logic [4:0]  rd_sticky_ff;
  logic        wr_en_ff;
  logic [63:0] wr_data_ff;
  logic        trap_ff;
  logic        accept;
  logic        dbl;
  logic        reserved;
  logic        arith;
  logic        ub;
  logic        a_zero, a_inf, a_nan, a_snan, a_den, a_risky, a_sign;
  logic        b_zero, b_inf, b_nan, b_snan, b_den, b_risky, b_sign;
  logic        snan, qnan, den, unord, inv;
  logic        v_cond, z_cond;
  logic [5:0]  iss_exc;
  logic        iss_trap;
  logic        possible;
  logic [5:0]  res_exc;
  logic        res_trap;
  logic        dflt_sign;
  logic [63:0] dflt_value;
  logic        rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic two_operand(input fpx_pkg::fpx_op_t o);
    case (o)
      fpx_pkg::OP_ADD, fpx_pkg::OP_SUB, fpx_pkg::OP_MUL, fpx_pkg::OP_DIV,
      fpx_pkg::OP_CMP_ORD, fpx_pkg::OP_CMP_UNORD: two_operand = 1'b1;
      default: two_operand = 1'b0;
    endcase
  endfunction : two_operand

  function automatic logic traps(input logic [5:0] x, input logic [4:0] en);
    traps = x[`FPX_EXC_E] || ((x[4:0] & en) != 5'h00);
  endfunction : traps

  ////////////////////////////////////////////////////////////////////////////
  // Operand classification
  assign op  = fpx_pkg::fpx_op_t'(issue_op);
  assign dbl = issue_instr[`FPX_FMT_MSB:`FPX_FMT_LSB] == `FPX_FMT_D;

  fpx_classify u_cls_a (
    .dbl     (dbl),
    .opnd    (op_a),
    .is_zero (a_zero),
    .is_inf  (a_inf),
    .is_nan  (a_nan),
    .is_snan (a_snan),
    .is_den  (a_den),
    .risky   (a_risky),
    .sign    (a_sign)
  );

  fpx_classify u_cls_b (
    .dbl     (dbl),
    .opnd    (op_b),
    .is_zero (b_zero),
    .is_inf  (b_inf),
    .is_nan  (b_nan),
    .is_snan (b_snan),
    .is_den  (b_den),
    .risky   (b_risky),
    .sign    (b_sign)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Issue-time detection
  assign reserved = (issue_instr[`FPX_OPC_MSB:`FPX_OPC_LSB] != `FPX_OPC_LEGAL) ||
                    ((issue_instr[`FPX_FMT_MSB:`FPX_FMT_LSB] != `FPX_FMT_S) &&
                     !dbl);
  assign arith = (op != fpx_pkg::OP_MOV);
  assign ub    = two_operand(op);
  assign snan  = arith && (a_snan || (ub && b_snan));
  // Quiet NaNs are left to software, except in ordered and unordered compares
  assign qnan  = arith && !snan && (op != fpx_pkg::OP_CMP_UNORD) &&
                 (op != fpx_pkg::OP_CMP_ORD) && (a_nan || (ub && b_nan));
  assign den   = arith && (a_den || (ub && b_den));
  assign unord = (op == fpx_pkg::OP_CMP_ORD) && (a_nan || b_nan);

  always_comb begin
    case (op)
      fpx_pkg::OP_ADD:     inv = a_inf && b_inf && (a_sign != b_sign);
      fpx_pkg::OP_SUB:     inv = a_inf && b_inf && (a_sign == b_sign);
      fpx_pkg::OP_MUL:     inv = (a_zero && b_inf) || (a_inf && b_zero);
      fpx_pkg::OP_DIV:     inv = (a_zero && b_zero) || (a_inf && b_inf);
      fpx_pkg::OP_CVT_FIX: inv = a_inf || a_nan;
      default:             inv = 1'b0;
    endcase
  end

  assign v_cond = snan || inv || unord;
  assign z_cond = (op == fpx_pkg::OP_DIV) && b_zero &&
                  !a_zero && !a_inf && !a_nan;

  always_comb begin
    iss_exc = 6'h00;
    if (reserved) begin
      iss_exc[`FPX_EXC_E] = 1'b1;
    end else if (qnan || den) begin
      iss_exc[`FPX_EXC_E] = 1'b1;
    end else if (v_cond) begin
      // No NaN is ever built here, so an untrapped invalid goes to software
      iss_exc[`FPX_EXC_V] = trap_en[`FPX_EXC_V];
      iss_exc[`FPX_EXC_E] = !trap_en[`FPX_EXC_V];
    end else if (z_cond) begin
      iss_exc[`FPX_EXC_Z] = 1'b1;
    end
  end

  assign iss_trap = traps(iss_exc, trap_en);

  // Inexact cannot be predicted, so enabled inexact traps serialise all long ops
  assign possible = a_risky || (ub && b_risky) ||
                    (trap_en[`FPX_EXC_I] && issue_multi);

  ////////////////////////////////////////////////////////////////////////////
  // Issue handshake
  // Result cycles and pending reads block issue, so issue never shares a cycle with a result or a read
  assign issue_ready    = (state_ff == fpx_pkg::ST_IDLE) && !csr_rd_req && !res_valid;
  assign accept         = issue_valid && issue_ready;
  assign issue_dispatch = accept && (iss_exc == 6'h00);
  assign issue_stalled  = issue_dispatch && possible;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fpx_pkg::ST_IDLE: begin
        if (issue_stalled) begin
          nxt_state = fpx_pkg::ST_STALL;
        end
      end
      fpx_pkg::ST_STALL: begin
        if (res_valid && (infl_ff == `FPX_INFL_W'(1))) begin
          nxt_state = fpx_pkg::ST_IDLE;
        end
      end
      default: nxt_state = fpx_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= fpx_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      infl_ff <= `FPX_INFL_W'(0);
    end else if (issue_dispatch) begin
      infl_ff <= infl_ff + `FPX_INFL_W'(1);
    end else if (res_valid && (infl_ff != `FPX_INFL_W'(0))) begin
      infl_ff <= infl_ff - `FPX_INFL_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result-time detection
  always_comb begin
    res_exc = 6'h00;
    res_exc[`FPX_EXC_E] = res_underflow || res_denorm ||
                          (res_cvt_ovf && !trap_en[`FPX_EXC_V]);
    res_exc[`FPX_EXC_V] = res_cvt_ovf && trap_en[`FPX_EXC_V];
    res_exc[`FPX_EXC_O] = res_overflow;
    res_exc[`FPX_EXC_I] = res_inexact || res_overflow;
    res_exc[`FPX_EXC_U] = 1'b0;
  end

  assign res_trap = traps(res_exc, trap_en);

  ////////////////////////////////////////////////////////////////////////////
  // Default results
  assign dflt_sign = res_valid ? res_sign : (a_sign ^ b_sign);

  fpx_default u_dflt (
    .dbl      (res_valid ? res_dbl : dbl),
    .sign     (dflt_sign),
    .div_zero (!res_valid),
    .rmode    (fpx_pkg::fpx_rmode_t'(round_mode)),
    .value    (dflt_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Destination write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_en_ff   <= 1'b0;
      wr_data_ff <= 64'h0;
    end else if (res_valid) begin
      wr_en_ff   <= !res_trap;
      wr_data_ff <= res_overflow ? dflt_value : res_value;
    end else if (accept && iss_exc[`FPX_EXC_Z]) begin
      wr_en_ff   <= !iss_trap;
      wr_data_ff <= dflt_value;
    end else begin
      wr_en_ff   <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trap_ff <= 1'b0;
    end else begin
      trap_ff <= (res_valid && res_trap) || (accept && iss_trap);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exceptions and sticky fields
  // An instruction with no exception leaves the field alone, so a pending
  // trap cause survives later clean completions
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      exc_ff <= `FPX_EXC_RST;
    end else if (res_valid && (res_exc != 6'h00)) begin
      exc_ff <= res_exc;
    end else if (accept && (iss_exc != 6'h00)) begin
      exc_ff <= iss_exc;
    end else if (csr_wr) begin
      exc_ff <= {csr_wr_exc[5:2], 1'b0, csr_wr_exc[0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sticky_ff <= `FPX_STICKY_RST;
    end else begin
      sticky_ff <= (csr_wr ? csr_wr_sticky & 5'h1D : sticky_ff) |
                   (res_valid ? res_exc[4:0] : 5'h00) |
                   (accept ? iss_exc[4:0] : 5'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status read
  // Waits for the pipe to drain so late exceptions are visible
  assign rd_ok = csr_rd_req && !rd_ack_ff && (infl_ff == `FPX_INFL_W'(0)) &&
                 !res_valid && !csr_wr;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_ack_ff    <= 1'b0;
      rd_exc_ff    <= `FPX_EXC_RST;
      rd_sticky_ff <= `FPX_STICKY_RST;
    end else begin
      rd_ack_ff <= rd_ok;
      if (rd_ok) begin
        rd_exc_ff    <= exc_ff;
        rd_sticky_ff <= sticky_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign csr_rd_ack    = rd_ack_ff;
  assign csr_rd_exc    = rd_exc_ff;
  assign csr_rd_sticky = rd_sticky_ff;
  assign wr_en         = wr_en_ff;
  assign wr_data       = wr_data_ff;
  assign exc_field     = exc_ff;
  assign sticky_field  = sticky_ff;
  assign trap_taken    = trap_ff;
  assign fp_irq        = traps(exc_ff, trap_en);

endmodule : fpx_exception_logic

// File: verification/fpx_exception_logic_monitor.sv
// Purpose: Port assertions for the floating point exception logic
// Assumes: One clock, srst synchronous active high
// Notes:   Default values are checked for single format only
`timescale 1ns/1ps
module fpx_exception_logic_monitor (
  input logic        sys_clk,
  input logic        srst,
  input logic        issue_valid,
  input logic [31:0] issue_instr,
  input logic        issue_ready,
  input logic        issue_dispatch,
  input logic        res_valid,
  input logic        res_dbl,
  input logic        res_sign,
  input logic        res_overflow,
  input logic        res_underflow,
  input logic        res_denorm,
  input logic        res_cvt_ovf,
  input logic [1:0]  round_mode,
  input logic [4:0]  trap_en,
  input logic        csr_wr,
  input logic [5:0]  csr_wr_exc,
  input logic        csr_rd_ack,
  input logic [5:0]  csr_rd_exc,
  input logic [4:0]  csr_rd_sticky,
  input logic        wr_en,
  input logic [63:0] wr_data,
  input logic [5:0]  exc_field,
  input logic [4:0]  sticky_field,
  input logic        trap_taken,
  input logic        fp_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////
  property p_no_under;
    !exc_field[1] && !sticky_field[1];
  endproperty
  a_no_under: assert property (p_no_under) else $error("U bit set");
  property p_ovf_val;
    res_valid && res_overflow && !res_dbl && !round_mode[1] && !trap_en[2] && !trap_en[0]
      && !res_underflow && !res_denorm && !res_cvt_ovf
      |=> wr_en && wr_data[31:0] == ({$past(res_sign), 31'h0}
      | ($past(round_mode) == 2'h1 ? 32'h7F7FFFFF : 32'h7F800000));
  endproperty
  a_ovf_val: assert property (p_ovf_val) else $error("bad overflow value");
  property p_ovf_flags;
    res_valid && res_overflow |=> exc_field[2] && exc_field[0] && sticky_field[0];
  endproperty
  a_ovf_flags: assert property (p_ovf_flags) else $error("bad overflow flags");
  property p_under;
    res_valid && (res_underflow || res_denorm) |=> trap_taken && !wr_en && exc_field[5];
  endproperty
  a_under: assert property (p_under) else $error("underflow not unimplemented");
  property p_resv;
    issue_valid && issue_ready && (issue_instr[31:26] != 6'h11 || issue_instr[24:22] != 3'h0)
      |-> !issue_dispatch ##1 exc_field[5];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved code accepted");
  property p_irq_lvl;
    fp_irq == (exc_field[5] | (|(exc_field[4:0] & trap_en)));
  endproperty
  a_irq_lvl: assert property (p_irq_lvl) else $error("bad interrupt level");
  property p_clear;
    csr_wr && csr_wr_exc == 6'h00 && !res_valid && !(issue_valid && issue_ready)
      |=> exc_field == 6'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("field not cleared");
  property p_rd;
    csr_rd_ack |-> csr_rd_exc == exc_field && csr_rd_sticky == sticky_field;
  endproperty
  a_rd: assert property (p_rd) else $error("bad read data");
  c_ovf: cover property (res_valid && res_overflow);
  c_resv: cover property (issue_valid && issue_ready && !issue_dispatch);
  c_rd: cover property (csr_rd_ack);
endmodule : fpx_exception_logic_monitor
bind fpx_exception_logic fpx_exception_logic_monitor fpx_exception_logic_monitor_i (.*);

// File: verification/fpx_core_model.sv
// Purpose: Integer core side model reading the status register
// Assumes: Request held until acknowledge is sampled high
// Notes:   Only the read path of the core is modelled
`timescale 1ns/1ps
module fpx_core_model (
  input  logic       sys_clk,
  input  logic       srst,
  input  logic       rd_go,
  input  logic       csr_rd_ack,
  input  logic [5:0] csr_rd_exc,
  input  logic [4:0] csr_rd_sticky,
  output logic       csr_rd_req,
  output logic       rd_done,
  output logic [5:0] rd_exc,
  output logic [4:0] rd_sticky
);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      csr_rd_req <= 1'h0;
      rd_done    <= 1'h0;
    end else if (rd_go) begin
      csr_rd_req <= 1'h1;
      rd_done    <= 1'h0;
    end else if (csr_rd_req && csr_rd_ack) begin
      // Drop at once, else a second read is taken
      csr_rd_req <= 1'h0;
      rd_done    <= 1'h1;
      rd_exc     <= csr_rd_exc;
      rd_sticky  <= csr_rd_sticky;
    end
  end
endmodule : fpx_core_model

// File: verification/test_fpx_exception_logic.sv
// Purpose: Self-checking bench for the floating point exception logic
// Assumes: Single format operands in the low 32 bits
// Notes:   Each scenario task judges its own outcome
`timescale 1ns/1ps
module test_fpx_exception_logic;
  localparam logic [31:0] INS  = 32'h44000000;
  localparam logic [63:0] ONE  = 64'h3F800000;
  localparam logic [63:0] ZERO = 64'h00000000;
  localparam logic [63:0] INF  = 64'h7F800000;
  localparam logic [63:0] SNAN = 64'h7FA00000;
  logic        sys_clk, srst, issue_valid, issue_multi, issue_ready, issue_dispatch;
  logic        issue_stalled, res_valid, res_dbl, res_sign, res_inexact, res_overflow;
  logic        res_underflow, res_denorm, res_cvt_ovf, csr_wr, csr_rd_req, csr_rd_ack;
  logic        wr_en, trap_taken, fp_irq, rd_go, rd_done, disp, stl;
  logic [31:0] issue_instr;
  logic [3:0]  issue_op;
  logic [63:0] op_a, op_b, res_value, wr_data;
  logic [1:0]  round_mode;
  logic [4:0]  trap_en, csr_wr_sticky, csr_rd_sticky, sticky_field, rd_sticky;
  logic [5:0]  csr_wr_exc, csr_rd_exc, exc_field, rd_exc;
  int          err_count, n_compared;
  fpx_exception_logic fpx_exception_logic_i (.*);
  fpx_core_model fpx_core_model_i (
    .sys_clk, .srst, .rd_go, .csr_rd_ack, .csr_rd_exc, .csr_rd_sticky, .csr_rd_req,
    .rd_done, .rd_exc, .rd_sticky
  );
  ////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic issue(input logic [31:0] ins, input logic [3:0] op, input logic [63:0] a,
                       input logic [63:0] b);
    int n;
    issue_instr = ins;
    issue_op    = op;
    op_a        = a;
    op_b        = b;
    issue_valid = 1'h1;
    #1;
    for (n = 0; n < 20 && issue_ready !== 1'h1; n++) tick();
    if (n == 20) begin
      err_count++;
      complete_run();
    end
    disp = issue_dispatch;
    stl  = issue_stalled;
    tick();
    issue_valid = 1'h0;
  endtask : issue
  // Flags are {cvt_ovf, denorm, underflow, overflow, inexact}
  task automatic result(input logic [4:0] f, input logic sgn);
    {res_cvt_ovf, res_denorm, res_underflow, res_overflow, res_inexact} = f;
    res_sign  = sgn;
    res_valid = 1'h1;
    tick();
    res_valid = 1'h0;
  endtask : result
  task automatic clear(input logic [4:0] st);
    csr_wr_sticky = st;
    csr_wr        = 1'h1;
    tick();
    csr_wr = 1'h0;
  endtask : clear
  task automatic wait_wr;
    for (int n = 0; n < 4 && wr_en !== 1'h1; n++) tick();
    chk("wr_en", wr_en, 1'h1);
  endtask : wait_wr
  ////////////////////////////////////////////////////
  task automatic s_overflow;
    for (int k = 0; k < 8; k++) begin
      round_mode = k[2:1];
      issue(INS, fpx_pkg::OP_MUL, 64'h7F000000, ONE);
      chk("stall", stl, 1'h1);
      result(5'h03, k[0]);
      chk("ovf wr", wr_en, 1'h1);
      chk("ovf val", wr_data[31:0], {k[0], 31'h0} | ((k[2:1] == 0 || k[2:1] == {1'h1, k[0]})
          ? 32'h7F800000 : 32'h7F7FFFFF));
      chk("ovf exc", exc_field, 6'h05);
    end
  endtask : s_overflow
  task automatic s_div;
    issue(INS, fpx_pkg::OP_DIV, 64'hBF800000, ZERO);
    chk("div disp", disp, 1'h0);
    chk("div exc", exc_field, 6'h08);
    chk("div sticky", sticky_field, 5'h0D);
    wait_wr();
    chk("div val", wr_data[31:0], 32'hFF800000);
    clear(5'h00);
    issue(INS, fpx_pkg::OP_DIV, INF, ZERO);
    chk("inf div", exc_field[3], 1'h0);
    if (disp) result(5'h00, 1'h0);
  endtask : s_div
  task automatic s_trap;
    trap_en = 5'h04;
    issue(INS, fpx_pkg::OP_ADD, ONE, ONE);
    result(5'h03, 1'h0);
    chk("trap", trap_taken, 1'h1);
    chk("trap wr", wr_en, 1'h0);
    tick();
    chk("irq", fp_irq, 1'h1);
    clear(5'h1F);
    chk("cleared", exc_field, 6'h00);
    chk("sticky", sticky_field, 5'h1D);
    chk("irq off", fp_irq, 1'h0);
    trap_en = 5'h00;
  endtask : s_trap
  task automatic s_result_e;
    for (int k = 0; k < 4; k++) begin
      trap_en = (k == 3) ? 5'h10 : 5'h00;
      issue(INS, fpx_pkg::OP_ADD, ONE, ONE);
      result(k < 3 ? 5'h04 << k : 5'h10, 1'h0);
      chk("res trap", trap_taken, 1'h1);
      chk("res exc", exc_field, k == 3 ? 6'h10 : 6'h20);
      chk("res irq", fp_irq, 1'h1);
      clear(5'h00);
    end
    trap_en = 5'h00;
  endtask : s_result_e
  task automatic s_resv;
    for (int k = 0; k < 2; k++) begin
      issue(k == 0 ? 32'h48000000 : 32'h44A00000, fpx_pkg::OP_ADD, ONE, ONE);
      chk("resv disp", disp, 1'h0);
      chk("resv exc", exc_field, 6'h20);
      chk("resv irq", fp_irq, 1'h1);
      clear(5'h00);
    end
  endtask : s_resv
  task automatic inv(input logic [3:0] op, input logic [63:0] a, input logic [63:0] b,
                     input logic tv, input logic [5:0] exp);
    trap_en = {tv, 4'h0};
    issue(INS, op, a, b);
    chk("inv disp", disp, 1'h0);
    chk("inv exc", exc_field, exp);
    chk("inv sticky", sticky_field[4], tv);
    clear(5'h00);
    trap_en = 5'h00;
  endtask : inv
  task automatic s_invalid;
    inv(fpx_pkg::OP_ABS, SNAN, ZERO, 1'h0, 6'h20);
    inv(fpx_pkg::OP_NEG, SNAN, ZERO, 1'h1, 6'h10);
    inv(fpx_pkg::OP_SUB, INF, INF, 1'h1, 6'h10);
    inv(fpx_pkg::OP_MUL, ZERO, INF, 1'h1, 6'h10);
    inv(fpx_pkg::OP_DIV, ZERO, ZERO, 1'h0, 6'h20);
    inv(fpx_pkg::OP_DIV, INF, INF, 1'h1, 6'h10);
    inv(fpx_pkg::OP_CVT_FIX, INF, ZERO, 1'h1, 6'h10);
    inv(fpx_pkg::OP_CMP_ORD, 64'h7FC00000, ONE, 1'h1, 6'h10);
    inv(fpx_pkg::OP_ADD, 64'h00400000, ONE, 1'h0, 6'h20);
    trap_en = 5'h10;
    issue(INS, fpx_pkg::OP_MOV, SNAN, ZERO);
    chk("mov", exc_field[4], 1'h0);
    if (disp) result(5'h00, 1'h0);
    trap_en = 5'h00;
    clear(5'h00);
  endtask : s_invalid
  task automatic s_stall;
    trap_en     = 5'h01;
    issue_multi = 1'h1;
    issue(INS, fpx_pkg::OP_DIV, ONE, ONE);
    chk("i stall", stl, 1'h1);
    chk("no issue", issue_ready, 1'h0);
    result(5'h01, 1'h0);
    chk("i trap", trap_taken, 1'h1);
    chk("i exc", exc_field, 6'h01);
    trap_en = 5'h00;
    issue(INS, fpx_pkg::OP_DIV, ONE, ONE);
    chk("no stall", stl, 1'h0);
    res_value = 64'h3F000000;
    result(5'h01, 1'h0);
    chk("rounded", wr_data, 64'h3F000000);
    clear(5'h00);
    issue_multi = 1'h0;
  endtask : s_stall
  task automatic s_read;
    int n;
    issue(32'h44200000, fpx_pkg::OP_DIV, 64'hBFF0000000000000, ZERO);
    wait_wr();
    chk("dbl div", wr_data, 64'hFFF0000000000000);
    tick();
    issue(INS, fpx_pkg::OP_ADD, ONE, ONE);
    rd_go = 1'h1;
    tick();
    rd_go = 1'h0;
    repeat (4) tick();
    chk("rd waits", rd_done, 1'h0);
    result(5'h01, 1'h0);
    for (n = 0; n < 30 && rd_done !== 1'h1; n++) tick();
    if (n == 30) begin
      err_count++;
      complete_run();
    end
    chk("rd exc", rd_exc, 6'h01);
    chk("rd sticky", rd_sticky, 5'h09);
  endtask : s_read
  ////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    err_count  = 0;
    n_compared = 0;
    {issue_valid, issue_multi, res_valid, res_dbl, res_sign, res_inexact, res_overflow} = '0;
    {res_underflow, res_denorm, res_cvt_ovf, csr_wr, rd_go, round_mode, trap_en} = '0;
    {issue_instr, issue_op, op_a, op_b, res_value, csr_wr_exc, csr_wr_sticky} = '0;
    srst = 1'h1;
    repeat (5) tick();
    srst = 1'h0;
    s_overflow();
    s_div();
    s_trap();
    s_result_e();
    s_resv();
    s_invalid();
    s_stall();
    s_read();
    complete_run();
  end
endmodule : test_fpx_exception_logic
